// [logic/ulsr_break_detect.sv]
// break detector: line held low for longer than one character time
`timescale 1ns/10ps
module ulsr_break_detect (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       rxLine,
   input  wire logic       rxBitTick,
   input  wire logic [2:0] charFormat,
   input  wire logic       parityEnable,
   output logic            breakPulse
);
   logic [3:0] lowCnt_ff;
   logic [3:0] nxt_lowCnt;
   logic       armed_ff;
   logic       nxt_armed;
   logic       pulse_ff;
   logic       nxt_pulse;
   logic [3:0] charBits;

   // -----------------------------------------------------------------
   // bit count of one character: start, data, parity, stop
   // -----------------------------------------------------------------
   always_comb begin
      charBits = ulsr_pkg::START_BITS + ulsr_pkg::DATA_BASE + {2'h0, charFormat[1:0]}
               + {3'h0, parityEnable} + ulsr_pkg::STOP_BASE + {3'h0, charFormat[2]};
   end

   // one pulse per break; rearmed only once the line returns high
   always_comb begin
      nxt_lowCnt = lowCnt_ff;
      nxt_armed  = armed_ff;
      nxt_pulse  = 1'b0;
      if (rxLine) begin
         nxt_lowCnt = 4'h0;
         nxt_armed  = 1'b1;
      end else if (rxBitTick && armed_ff) begin
         if (lowCnt_ff > charBits) begin
            nxt_pulse = 1'b1;
            nxt_armed = 1'b0;
            nxt_lowCnt = 4'h0;
         end else begin
            nxt_lowCnt = lowCnt_ff + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         lowCnt_ff <= 4'h0;
         armed_ff  <= 1'b0;
         pulse_ff  <= 1'b0;
      end else begin
         lowCnt_ff <= nxt_lowCnt;
         armed_ff  <= nxt_armed;
         pulse_ff  <= nxt_pulse;
      end
   end

   assign breakPulse = pulse_ff;
endmodule

// [logic/ulsr_line_status.sv]
// line status flags of the serial port with an AXI4-Lite register slave
`timescale 1ns/10ps
module ulsr_line_status (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rxLine,
   input  wire logic        rxBitTick,
   input  wire logic        rxCharDone,
   input  wire logic        rxCharParErr,
   input  wire logic        rxCharFrmErr,
   input  wire logic        rxFifoFull,
   input  wire logic        rxFifoLast,
   input  wire logic        rxBufRead,
   input  wire logic        rxHeadLoad,
   input  wire logic        rxHeadParErr,
   input  wire logic        rxHeadFrmErr,
   input  wire logic        rxHeadPop,
   input  wire logic        rxHeadErr,
   input  wire logic        txFifoEmpty,
   input  wire logic        txShiftEmpty,
   input  wire logic        txIdle,
   output logic             rxPush,
   output logic             rxPushParErr,
   output logic             rxPushFrmErr,
   output logic             fifoEnabled,
   output logic             txBreakCmd
);
   // -----------------------------------------------------------------
   // bus slave state
   // -----------------------------------------------------------------
   logic        awready_ff, nxt_awready, wready_ff, nxt_wready;
   logic        awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
   logic [3:0]  awAddr_ff, nxt_awAddr;
   logic [31:0] wData_ff, nxt_wData;
   logic [3:0]  wStrb_ff, nxt_wStrb;
   logic        bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
   logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [5:0]  ctrl_ff, nxt_ctrl;
   logic        awTake, wTake, doWrite, arTake, lsrRead;
   // -----------------------------------------------------------------
   // flag state
   // -----------------------------------------------------------------
   logic        err_ff, nxt_err, transmitter_empty_ff, nxt_transmitter_empty, tx_holding_empty_ff, nxt_tx_holding_empty;
   logic        brk_ff, nxt_brk, frm_ff, nxt_frm, par_ff, nxt_par;
   logic        ovr_ff, nxt_ovr, rdy_ff, nxt_rdy;
   logic        push_ff, nxt_push, pushPar_ff, nxt_pushPar, pushFrm_ff, nxt_pushFrm;
   logic [4:0]  errCnt_ff, nxt_errCnt;
   logic        breakPulse, fifoOn, brkCmd, rxEvent, rxDrop;
   logic [7:0]  lsrVec;

   assign fifoOn = ctrl_ff[ulsr_pkg::CTRL_FIFO_BIT];
   assign brkCmd = ctrl_ff[ulsr_pkg::CTRL_BRK_BIT];

   ulsr_break_detect u_break (
      .clock        (clock),
      .rst          (rst),
      .rxLine       (rxLine),
      .rxBitTick    (rxBitTick),
      .charFormat   (ctrl_ff[ulsr_pkg::CTRL_FMT_MSB:ulsr_pkg::CTRL_FMT_LSB]),
      .parityEnable (ctrl_ff[ulsr_pkg::CTRL_PAR_BIT]),
      .breakPulse   (breakPulse)
   );

   // -----------------------------------------------------------------
   // AXI4-Lite slave
   // -----------------------------------------------------------------
   always_comb begin
      awTake      = s_axi_awvalid && awready_ff;
      wTake       = s_axi_wvalid && wready_ff;
      doWrite     = awHeld_ff && wHeld_ff && !bvalid_ff;
      arTake      = s_axi_arvalid && arready_ff;
      lsrRead     = arTake && (s_axi_araddr == ulsr_pkg::LSR_OFS);
      nxt_awAddr  = awTake ? s_axi_awaddr : awAddr_ff;
      nxt_wData   = wTake ? s_axi_wdata : wData_ff;
      nxt_wStrb   = wTake ? s_axi_wstrb : wStrb_ff;
      nxt_awHeld  = (awHeld_ff && !doWrite) || awTake;
      nxt_wHeld   = (wHeld_ff && !doWrite) || wTake;
      nxt_bvalid  = doWrite || (bvalid_ff && !s_axi_bready);
      nxt_awready = !nxt_awHeld && !nxt_bvalid;
      nxt_wready  = !nxt_wHeld && !nxt_bvalid;
      nxt_bresp   = bresp_ff;
      nxt_ctrl    = ctrl_ff;
      if (doWrite) begin
         // status is read-only: a write to it is refused with an error
         if (awAddr_ff == ulsr_pkg::CTRL_OFS) begin
            nxt_bresp = ulsr_pkg::RESP_OKAY;
            if (wStrb_ff[0]) begin
               nxt_ctrl = wData_ff[5:0];
            end
         end else begin
            nxt_bresp = ulsr_pkg::RESP_SLVERR;
         end
      end
      nxt_rvalid  = arTake || (rvalid_ff && !s_axi_rready);
      nxt_arready = !nxt_rvalid;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      if (arTake) begin
         nxt_rresp = ulsr_pkg::RESP_OKAY;
         nxt_rdata = 32'h0000_0000;
         if (lsrRead) begin
            nxt_rdata[7:0] = lsrVec;
         end else if (s_axi_araddr == ulsr_pkg::CTRL_OFS) begin
            nxt_rdata[5:0] = ctrl_ff;
         end else begin
            nxt_rresp = ulsr_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         awHeld_ff  <= 1'b0;
         wHeld_ff   <= 1'b0;
         awAddr_ff  <= 4'h0;
         wData_ff   <= 32'h0000_0000;
         wStrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= ulsr_pkg::RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= ulsr_pkg::RESP_OKAY;
         rdata_ff   <= 32'h0000_0000;
         ctrl_ff    <= ulsr_pkg::CTRL_RESET;
      end else begin
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         awHeld_ff  <= nxt_awHeld;
         wHeld_ff   <= nxt_wHeld;
         awAddr_ff  <= nxt_awAddr;
         wData_ff   <= nxt_wData;
         wStrb_ff   <= nxt_wStrb;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rresp_ff   <= nxt_rresp;
         rdata_ff   <= nxt_rdata;
         ctrl_ff    <= nxt_ctrl;
      end
   end

   // -----------------------------------------------------------------
   // receive side: storing, error counting, flags
   // -----------------------------------------------------------------
   always_comb begin
      rxEvent     = rxCharDone || (fifoOn && breakPulse);
      rxDrop      = fifoOn && rxFifoFull;
      nxt_push    = rxEvent && !rxDrop;
      // with the FIFO enabled, a break queues a single null character carrying a framing error
      nxt_pushFrm = rxCharDone ? rxCharFrmErr : breakPulse;
      nxt_pushPar = rxCharDone && rxCharParErr;
      nxt_errCnt  = errCnt_ff;
      if (!fifoOn) begin
         nxt_errCnt = ulsr_pkg::ERR_CNT_ZERO;
      end else if (nxt_push && (nxt_pushFrm || nxt_pushPar) && !(rxHeadPop && rxHeadErr)) begin
         nxt_errCnt = errCnt_ff + ulsr_pkg::ERR_CNT_ONE;
      end else if (!(nxt_push && (nxt_pushFrm || nxt_pushPar)) && rxHeadPop && rxHeadErr
                   && errCnt_ff != ulsr_pkg::ERR_CNT_ZERO) begin
         nxt_errCnt = errCnt_ff - ulsr_pkg::ERR_CNT_ONE;
      end
      // each flag: the set term is applied after the clear so it wins
      nxt_err = fifoOn && ((err_ff && !lsrRead) || errCnt_ff != ulsr_pkg::ERR_CNT_ZERO);
      nxt_brk = (brk_ff && !lsrRead) || breakPulse;
      nxt_frm = (frm_ff && !lsrRead) || (rxHeadLoad && rxHeadFrmErr)
              || (!fifoOn && breakPulse);
      nxt_par = (par_ff && !lsrRead) || (rxHeadLoad && rxHeadParErr);
      nxt_ovr = (ovr_ff && !lsrRead)
              || (rxCharDone && !fifoOn && rdy_ff && !rxBufRead)
              || (rxCharDone && rxDrop);
      nxt_rdy = (rdy_ff && !(rxBufRead && (!fifoOn || rxFifoLast)))
              || (rxEvent && !rxDrop);
      // transmitter flags held low for as long as a break is commanded
      nxt_tx_holding_empty = txFifoEmpty && !brkCmd;
      nxt_transmitter_empty = txFifoEmpty && txShiftEmpty && txIdle && !brkCmd;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         err_ff     <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_ERR_BIT];
         transmitter_empty_ff    <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_TRANSMITTER_EMPTY_BIT];
         tx_holding_empty_ff    <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_TX_HOLDING_EMPTY_BIT];
         brk_ff     <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_BRK_BIT];
         frm_ff     <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_FRM_BIT];
         par_ff     <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_PAR_BIT];
         ovr_ff     <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_OVR_BIT];
         rdy_ff     <= ulsr_pkg::LSR_RESET[ulsr_pkg::LSR_RDY_BIT];
         errCnt_ff  <= ulsr_pkg::ERR_CNT_ZERO;
         push_ff    <= 1'b0;
         pushPar_ff <= 1'b0;
         pushFrm_ff <= 1'b0;
      end else begin
         err_ff     <= nxt_err;
         transmitter_empty_ff    <= nxt_transmitter_empty;
         tx_holding_empty_ff    <= nxt_tx_holding_empty;
         brk_ff     <= nxt_brk;
         frm_ff     <= nxt_frm;
         par_ff     <= nxt_par;
         ovr_ff     <= nxt_ovr;
         rdy_ff     <= nxt_rdy;
         errCnt_ff  <= nxt_errCnt;
         push_ff    <= nxt_push;
         pushPar_ff <= nxt_push && nxt_pushPar;
         pushFrm_ff <= nxt_push && nxt_pushFrm;
      end
   end

   always_comb begin
      lsrVec = {err_ff, transmitter_empty_ff, tx_holding_empty_ff, brk_ff, frm_ff, par_ff, ovr_ff, rdy_ff};
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign rxPush        = push_ff;
   assign rxPushParErr  = pushPar_ff;
   assign rxPushFrmErr  = pushFrm_ff;
   assign fifoEnabled   = ctrl_ff[ulsr_pkg::CTRL_FIFO_BIT];
   assign txBreakCmd    = ctrl_ff[ulsr_pkg::CTRL_BRK_BIT];

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_statusRead;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == ulsr_pkg::LSR_OFS);
   endsequence

   property p_errOff;
      !fifoOn |=> !err_ff;
   endproperty
   a_errOff: assert property (p_errOff) else $error("error summary set with fifo off");

   property p_errHeld;
      (fifoOn && errCnt_ff != ulsr_pkg::ERR_CNT_ZERO) |=> err_ff;
   endproperty
   a_errHeld: assert property (p_errHeld) else $error("error summary low with errors queued");

   property p_temtCause;
      !(txFifoEmpty && txShiftEmpty && txIdle) |=> !transmitter_empty_ff;
   endproperty
   a_temtCause: assert property (p_temtCause) else $error("transmitter empty while busy");

   property p_breakTx;
      brkCmd |=> (!transmitter_empty_ff && !tx_holding_empty_ff);
   endproperty
   a_breakTx: assert property (p_breakTx) else $error("tx empty flags set during break");

   property p_threData;
      !txFifoEmpty |=> !tx_holding_empty_ff;
   endproperty
   a_threData: assert property (p_threData) else $error("holding empty with data queued");

   property p_breakSets;
      breakPulse |=> brk_ff;
   endproperty
   a_breakSets: assert property (p_breakSets) else $error("break not flagged");

   property p_readClears;
      (s_statusRead and !breakPulse && !rxHeadLoad && !rxCharDone) |=> (!brk_ff && !frm_ff && !ovr_ff);
   endproperty
   a_readClears: assert property (p_readClears) else $error("status read left flags set");

   property p_fullDrop;
      (rxCharDone && fifoOn && rxFifoFull) |=> (ovr_ff && !rxPush);
   endproperty
   a_fullDrop: assert property (p_fullDrop) else $error("full fifo overrun mishandled");

   property p_readyOnStore;
      (rxCharDone && !(fifoOn && rxFifoFull)) |=> (rdy_ff && rxPush);
   endproperty
   a_readyOnStore: assert property (p_readyOnStore) else $error("data ready not set on store");

   property p_readOld;
      s_statusRead |=> (s_axi_rvalid && s_axi_rdata[7:0] == $past(lsrVec));
   endproperty
   a_readOld: assert property (p_readOld) else $error("status read returned wrong value");

   property p_readyClears;
      (rxBufRead && (!fifoOn || rxFifoLast) && !rxCharDone && !breakPulse) |=> !rdy_ff;
   endproperty
   a_readyClears: assert property (p_readyClears) else $error("data ready not cleared");

   property p_overrunUnbuf;
      (rxCharDone && !fifoOn && rdy_ff && !rxBufRead) |=> ovr_ff;
   endproperty
   a_overrunUnbuf: assert property (p_overrunUnbuf) else $error("unbuffered overrun missed");

   property p_breakEntry;
      (fifoOn && breakPulse && !rxCharDone && !rxFifoFull) |=> (rxPush && rxPushFrmErr && !rxPushParErr);
   endproperty
   a_breakEntry: assert property (p_breakEntry) else $error("break entry not queued");

   property p_headFrame;
      (rxHeadLoad && rxHeadFrmErr) |=> frm_ff;
   endproperty
   a_headFrame: assert property (p_headFrame) else $error("framing flag missed at head");
endmodule

// [logic/ulsr_pkg.sv]
// constants of the line status block: register map, field layout, reset values
package ulsr_pkg;
   // -----------------------------------------------------------------
   // register bus
   // -----------------------------------------------------------------
   localparam int          ADDR_W         = 4;
   localparam int          DATA_W         = 32;
   localparam logic [3:0]  LSR_OFS        = 4'h0;
   localparam logic [3:0]  CTRL_OFS       = 4'h4;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // -----------------------------------------------------------------
   // line status fields
   // -----------------------------------------------------------------
   localparam int          LSR_ERR_BIT    = 7;
   localparam int          LSR_TRANSMITTER_EMPTY_BIT   = 6;
   localparam int          LSR_TX_HOLDING_EMPTY_BIT   = 5;
   localparam int          LSR_BRK_BIT    = 4;
   localparam int          LSR_FRM_BIT    = 3;
   localparam int          LSR_PAR_BIT    = 2;
   localparam int          LSR_OVR_BIT    = 1;
   localparam int          LSR_RDY_BIT    = 0;
   localparam logic [7:0]  LSR_RESET      = 8'h60;
   // -----------------------------------------------------------------
   // control fields
   // -----------------------------------------------------------------
   localparam int          CTRL_FIFO_BIT  = 0;
   localparam int          CTRL_BRK_BIT   = 1;
   localparam int          CTRL_PAR_BIT   = 2;
   localparam int          CTRL_FMT_LSB   = 3;
   localparam int          CTRL_FMT_MSB   = 5;
   localparam logic [5:0]  CTRL_RESET     = 6'h00;
   // -----------------------------------------------------------------
   // character format and counters
   // -----------------------------------------------------------------
   localparam logic [3:0]  START_BITS     = 4'h1;
   localparam logic [3:0]  DATA_BASE      = 4'h5;
   localparam logic [3:0]  STOP_BASE      = 4'h1;
   localparam int          ERR_CNT_W      = 5;
   localparam logic [4:0]  ERR_CNT_ONE    = 5'h01;
   localparam logic [4:0]  ERR_CNT_ZERO   = 5'h00;
endpackage

// [tb/ulsr_far_model.sv]
// far side model: remote serial sender plus receive FIFO occupancy
`timescale 1ns/10ps
module ulsr_far_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       breakOn,
   input  wire logic       sendReq,
   input  wire logic       sendPar,
   input  wire logic       sendFrm,
   input  wire logic       popReq,
   input  wire logic       fifoEnabled,
   input  wire logic       rxPush,
   input  wire logic       rxPushParErr,
   input  wire logic       rxPushFrmErr,
   output logic            rxLine,
   output logic            rxBitTick,
   output logic            rxCharDone,
   output logic            rxCharParErr,
   output logic            rxCharFrmErr,
   output logic            rxFifoFull,
   output logic            rxFifoLast,
   output logic            rxHeadLoad,
   output logic            rxHeadParErr,
   output logic            rxHeadFrmErr,
   output logic            rxHeadPop,
   output logic            rxHeadErr,
   output logic [2:0]      fill
);
   logic [1:0] tickCnt;
   logic [1:0] tagQ[$];
   assign rxLine     = ~breakOn;
   assign rxBitTick  = (tickCnt == 2'h3);
   assign rxFifoFull = (fill == 3'h4);
   assign rxFifoLast = (fill == 3'h1);
   // -----------------------------------------------------------------
   // sender and four-deep FIFO
   // -----------------------------------------------------------------
   always @(posedge clock) begin
      tickCnt      <= rst ? 2'h0 : tickCnt + 2'h1;
      rxCharDone   <= sendReq;
      rxCharParErr <= sendReq ? sendPar : 1'b0;
      rxCharFrmErr <= sendReq ? sendFrm : 1'b0;
      rxHeadLoad   <= 1'b0;
      rxHeadPop    <= popReq;
      rxHeadErr    <= (tagQ.size() > 0) ? |tagQ[0] : 1'b0;
      if (rst) begin
         tagQ.delete();
      end
      if (popReq && tagQ.size() > 0) begin
         void'(tagQ.pop_front());
         if (tagQ.size() > 0) begin
            rxHeadLoad <= 1'b1;
            {rxHeadParErr, rxHeadFrmErr} <= tagQ[0];
         end
      end
      if (rxPush && fifoEnabled && tagQ.size() < 4) begin
         if (tagQ.size() == 0) begin
            rxHeadLoad <= 1'b1;
            {rxHeadParErr, rxHeadFrmErr} <= {rxPushParErr, rxPushFrmErr};
         end
         tagQ.push_back({rxPushParErr, rxPushFrmErr});
      end
      fill <= 3'(tagQ.size());
   end
endmodule

// [tb/ulsr_tb.sv]
// self-checking bench of the line status block
`timescale 1ns/10ps
module tb;
   logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic rxLine, rxBitTick, rxCharDone, rxCharParErr, rxCharFrmErr, rxFifoFull, rxFifoLast, rxBufRead;
   logic rxHeadLoad, rxHeadParErr, rxHeadFrmErr, rxHeadPop, rxHeadErr, txFifoEmpty, txShiftEmpty, txIdle;
   logic rxPush, rxPushParErr, rxPushFrmErr, fifoEnabled, txBreakCmd;
   logic breakOn, sendReq, sendPar, sendFrm, popReq;
   logic [2:0]  fill;
   logic [31:0] rd;
   int n_errors, num_checks, cyc;

   ulsr_line_status uut (.*);
   ulsr_far_model far (.*);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // -----------------------------------------------------------------
   // verdict, watchdog and compares
   // -----------------------------------------------------------------
   task automatic report_and_stop();
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t value %h want %h", $time, got, exp);
      end
   endtask
   // -----------------------------------------------------------------
   // register bus master
   // -----------------------------------------------------------------
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic axi_rd(input logic [3:0] a);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata; rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd_st(input logic [7:0] m, input logic [7:0] e);
      axi_rd(ulsr_pkg::LSR_OFS);
      num_checks++;
      if ((rd[7:0] & m) !== (e & m) || rsp !== ulsr_pkg::RESP_OKAY) begin
         n_errors++;
         $display("BAD %0t status %h want %h mask %h", $time, rd[7:0], e, m);
      end
   endtask
   // -----------------------------------------------------------------
   // far side stimulus
   // -----------------------------------------------------------------
   task automatic send(input logic p, input logic f);
      sendPar <= p; sendFrm <= f; sendReq <= 1'b1;
      @(posedge clock);
      sendReq <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task automatic pop();
      rxBufRead <= 1'b1; popReq <= 1'b1;
      @(posedge clock);
      rxBufRead <= 1'b0; popReq <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task automatic brk();
      breakOn <= 1'b1;
      repeat (80) @(posedge clock);
      breakOn <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0; s_axi_rready = 0;
      s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0; s_axi_wstrb = 4'h0; s_axi_wdata = 32'h0;
      rxBufRead = 0; txFifoEmpty = 1; txShiftEmpty = 1; txIdle = 1;
      breakOn = 0; sendReq = 0; sendPar = 0; sendFrm = 0; popReq = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd_st(8'hff, ulsr_pkg::LSR_RESET);
      axi_wr(ulsr_pkg::LSR_OFS, 32'hff);
      chk_v(rsp, ulsr_pkg::RESP_SLVERR);
      rd_st(8'hff, 8'h60);
      axi_rd(4'h8);
      chk_v(rsp, ulsr_pkg::RESP_SLVERR);
      chk_v(rd, 32'h0);
      // unbuffered receive: data ready, overrun, clears
      axi_wr(ulsr_pkg::CTRL_OFS, 32'h18);
      chk_v(rsp, ulsr_pkg::RESP_OKAY);
      send(1'b0, 1'b0);
      rd_st(8'hff, 8'h61);
      send(1'b0, 1'b0);
      rd_st(8'hff, 8'h63);
      rd_st(8'hff, 8'h61);
      pop();
      rd_st(8'hff, 8'h60);
      brk();
      rd_st(8'h98, 8'h18);
      rd_st(8'h1e, 8'h00);
      // transmitter flags
      // the flags follow the inputs one edge later
      txFifoEmpty <= 1'b0;
      @(posedge clock);
      rd_st(8'h60, 8'h00);
      txFifoEmpty <= 1'b1; txShiftEmpty <= 1'b0;
      @(posedge clock);
      rd_st(8'h60, 8'h20);
      txShiftEmpty <= 1'b1; txIdle <= 1'b0;
      @(posedge clock);
      rd_st(8'h60, 8'h20);
      txIdle <= 1'b1;
      axi_wr(ulsr_pkg::CTRL_OFS, 32'h1a);
      chk_v(txBreakCmd, 1'b1);
      rd_st(8'h60, 8'h00);
      axi_wr(ulsr_pkg::CTRL_OFS, 32'h18);
      rd_st(8'h60, 8'h60);
      // buffered receive: error summary, head flags, break entry, overrun
      // parity on and two stop bits lengthen the break threshold
      axi_wr(ulsr_pkg::CTRL_OFS, 32'h3d);
      chk_v(fifoEnabled, 1'b1);
      send(1'b1, 1'b0);
      rd_st(8'hff, 8'he5);
      rd_st(8'hff, 8'he1);
      pop();
      rd_st(8'hff, 8'he0);
      rd_st(8'hff, 8'h60);
      send(1'b0, 1'b1);
      rd_st(8'h8c, 8'h88);
      pop();
      rd_st(8'hff, 8'he0);
      brk();
      chk_v(fill, 3'h1);
      rd_st(8'h9d, 8'h99);
      pop();
      rd_st(8'hff, 8'he0);
      repeat (4) send(1'b0, 1'b0);
      chk_v(fill, 3'h4);
      send(1'b0, 1'b0);
      chk_v(fill, 3'h4);
      rd_st(8'h83, 8'h03);
      rd_st(8'h02, 8'h00);
      axi_wr(ulsr_pkg::CTRL_OFS, 32'h18);
      rd_st(8'h80, 8'h00);
      report_and_stop();
   end
endmodule
